// ===== dicd_top.sv
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - start edge begins layer only when idle
// - stop edge issues a stop command
// - deposit-end edge ends deposit like final thickness
// - trigger edge starts rate sample if film enabled
// - grounded inhibit holds rate sampler
// - grounded inhibit blocks crystal-fail relay and stop
// - thickness-zero edge acts like front-panel zero
// - grounded hold keeps second soak state
// - source 1 valid gates sequencing, shared single-source
// - source 2 valid gates source 2 sequencing
// - reset edge resets only while stopped
// - process inputs sampled at start in ready/last idle
// - two inputs: 00..11 map to processes 1..4
// - four inputs select processes 1 through 16
module dicd_top
  import dicd_pkg::*;
#(
  parameter int DBNC_LEN = DBNC_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic start_n,
  input wire logic stop_n,
  input wire logic deposit_end_n,
  input wire logic rate_sample_trig_n,
  input wire logic rate_sample_inhibit_n,
  input wire logic crystal_fault_inhibit_n,
  input wire logic thick_zero_n,
  input wire logic soak2_hold_n,
  input wire logic cruc1_valid_n,
  input wire logic cruc2_valid_n,
  input wire logic reset_n_in,
  input wire logic [3:0] proc_sel_n,
  input wire logic seq_running,
  input wire logic seq_stopped,
  input wire logic seq_ready_or_last_idle,
  input wire logic seq_in_deposit,
  input wire logic film_rate_sample_en,
  input wire logic seq_wait_cruc1,
  input wire logic seq_wait_cruc2,
  input wire logic crystal_fault_det,
  output logic cmd_start,
  output logic cmd_stop,
  output logic cmd_deposit_end,
  output logic cmd_rate_sample,
  output logic cmd_thick_zero,
  output logic cmd_reset,
  output logic rate_sample_hold,
  output logic crystal_fail_relay,
  output logic crystal_fail_stop,
  output logic soak2_hold,
  output logic cruc_proceed,
  output logic proc_load,
  output logic [4:0] proc_num
);

  // input conditioning
  // every discrete pin is a closure to ground, so a low pin is active
  // and a released pin is pulled high outside the block
  // each pin has its own synchroniser and stable-window filter; one
  // filter per pin costs area but keeps a chattering contact on one
  // input from disturbing any other
  // limitation: a closure shorter than the window is never seen
  // from the filter outputs on, levels are active high
  logic [NUM_IN-1:0] pin_vec_n; // raw pins, low = active
  logic [NUM_IN-1:0] lvl; // debounced, high = grounded
  logic [NUM_IN-1:0] act; // debounced and enabled by mask
  logic [NUM_IN-1:0] prev_ff; // previous act sample
  logic [NUM_IN-1:0] fall; // one-cycle falling-edge marks

  // pins gathered in the bit order of the mask and level registers
  assign pin_vec_n = {proc_sel_n, reset_n_in, cruc2_valid_n, cruc1_valid_n,
                      soak2_hold_n, thick_zero_n, crystal_fault_inhibit_n,
                      rate_sample_inhibit_n, rate_sample_trig_n, deposit_end_n,
                      stop_n, start_n};

  // one filter per pin; every pin is a contact closure
  // the window length is a parameter so a bench can use a short one
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in
      dicd_debounce #(
        .CNT_W(DBNC_CNT_W),
        .CYCLES(DBNC_LEN)
      ) u_dbnc (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_n(pin_vec_n[gi]),
        .level_ff(lvl[gi])
      );
    end
  endgenerate

  // register state
  // control, mask and the sticky event log live here; the sequencer
  // itself sits outside and sees only pulses and levels
  // a cleared mask bit makes its input look released, so software can
  // silence a broken contact without touching the wiring
  // the mask acts after the filter, so the level register still shows
  // the true pin state for diagnosis
  logic [1:0] ctrl_ff; // sel16 and single-source bits
  logic [NUM_IN-1:0] mask_ff; // per-input enable
  logic [NUM_EV-1:0] event_ff; // sticky, write one to clear
  logic [NUM_EV-1:0] ev_set; // hardware event strobes
  logic [NUM_EV-1:0] ev_clr; // software clear strobes
  logic sel16; // four-input process select
  logic single_src; // source 2 shares source 1 valid

  // control bits decoded once here and used throughout
  assign sel16 = ctrl_ff[CTRL_SEL16_BIT];
  assign single_src = ctrl_ff[CTRL_SINGLE_SRC_BIT];
  assign act = lvl & mask_ff;

  // edge detector works on the filtered level, never on a sync stage
  // a zero reset matches the released level, so reset makes no edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff <= '0;
    end else begin
      prev_ff <= act;
    end
  end

  // note: enabling a masked input that is already grounded shows as an
  // edge; software should enable inputs while they are released
  assign fall = act & ~prev_ff;

  // edge commands
  // an edge is a released-to-grounded change of the masked level
  // each edge gives at most one registered command pulse, gated by the
  // sequencer status seen in the same cycle as the edge
  // gating here instead of queueing means a refused edge is dropped for
  // good; a start that fired seconds later would surprise the operator
  // a refused start or reset still leaves a mark in the event log
  logic start_ok; // start accepted this cycle
  logic reset_ok; // reset accepted this cycle
  logic rs_ok; // rate sample accepted this cycle
  logic start_refused; // start edge while a layer runs
  logic reset_refused; // reset edge outside the stopped condition
  logic refused; // a start or reset edge was dropped
  logic [3:0] sel_lvl; // process select inputs, grounded = 1

  assign start_ok = fall[IN_START] && !seq_running;
  assign reset_ok = fall[IN_RESET] && seq_stopped;
  // held sampler ignores triggers; hold means no new sample
  assign rs_ok = fall[IN_RS_TRIG] && film_rate_sample_en && !act[IN_RS_INHIB];
  assign start_refused = fall[IN_START] && seq_running;
  assign reset_refused = fall[IN_RESET] && !seq_stopped;
  assign refused = start_refused || reset_refused;
  assign sel_lvl = act[IN_SEL0+3:IN_SEL0];

  // command pulses, one clock each, registered
  // registering costs a cycle of latency but gives glitch-free pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_start <= 1'b0;
      cmd_stop <= 1'b0;
      cmd_deposit_end <= 1'b0;
      cmd_rate_sample <= 1'b0;
      cmd_thick_zero <= 1'b0;
      cmd_reset <= 1'b0;
    end else begin
      cmd_start <= start_ok;
      cmd_stop <= fall[IN_STOP];
      // only meaningful in deposit; elsewhere it would end nothing
      cmd_deposit_end <= fall[IN_DEP_END] && seq_in_deposit;
      cmd_rate_sample <= rs_ok;
      cmd_thick_zero <= fall[IN_THK_ZERO];
      cmd_reset <= reset_ok;
    end
  end

  // process number, latched with the start that samples it
  // grounded select inputs read as ones, so all released picks 1
  // any other start leaves the last number standing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      proc_num <= 5'h01;
      proc_load <= 1'b0;
    end else begin
      proc_load <= 1'b0;
      if (start_ok && seq_ready_or_last_idle) begin
        proc_load <= 1'b1;
        if (sel16) begin
          proc_num <= {1'b0, sel_lvl} + 5'h01;
        end else begin
          proc_num <= {3'h0, sel_lvl[1:0]} + 5'h01;
        end
      end
    end
  end

  // level qualifiers
  // these inputs act for as long as they are grounded, not on edges
  // each is registered once more so the sequencer sees a single clean
  // transition for every filtered change
  // the proceed level is raised only while the sequencer is waiting on
  // a crucible; outside a crucible switch it stays low, so a crucible
  // left in place cannot let a later switch through early
  logic cruc2_src; // valid input serving source 2

  // on a single-source unit the source 1 input also serves source 2
  assign cruc2_src = single_src ? act[IN_CRUC1_OK] : act[IN_CRUC2_OK];

  // registered so sequencer sees glitch-free levels
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_sample_hold <= 1'b0;
      crystal_fail_relay <= 1'b0;
      crystal_fail_stop <= 1'b0;
      soak2_hold <= 1'b0;
      cruc_proceed <= 1'b0;
    end else begin
      rate_sample_hold <= act[IN_RS_INHIB];
      // relay and stop share one term: an inhibited fault does neither
      crystal_fail_relay <= crystal_fault_det && !act[IN_XF_INHIB];
      crystal_fail_stop <= crystal_fault_det && !act[IN_XF_INHIB];
      soak2_hold <= act[IN_SOAK2_HOLD];
      if (seq_wait_cruc1) begin
        cruc_proceed <= act[IN_CRUC1_OK];
      end else if (seq_wait_cruc2) begin
        cruc_proceed <= cruc2_src;
      end else begin
        cruc_proceed <= 1'b0;
      end
    end
  end

  // sticky event log
  // one bit per accepted command, plus one for a refused start or reset
  // software reads the log to learn what the contacts did while it was
  // busy, then writes ones to clear the bits it has handled
  // hazard: an event in the same cycle as its clear must not be lost,
  // so the set term is applied after the clear term
  always_comb begin
    ev_set = '0;
    ev_set[EV_START] = start_ok;
    ev_set[EV_STOP] = fall[IN_STOP];
    ev_set[EV_DEP_END] = fall[IN_DEP_END] && seq_in_deposit;
    ev_set[EV_RS_TRIG] = rs_ok;
    ev_set[EV_THK_ZERO] = fall[IN_THK_ZERO];
    ev_set[EV_RESET] = reset_ok;
    ev_set[EV_REFUSED] = refused;
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_ff <= '0;
    end else begin
      event_ff <= (event_ff & ~ev_clr) | ev_set;
    end
  end

  // ahb-lite slave, zero wait states
  // every register answers in one cycle, so hreadyout never drops and
  // hresp stays okay; back-to-back transfers need no spacing
  // only whole-word transfers are taken; other sizes are ignored but
  // still answered okay, as no register has byte lanes worth keeping
  // reads are decoded in the address phase and registered, writes wait
  // for the data phase where hwdata stands
  // only the low address byte is decoded, so the map repeats upwards
  logic acc; // valid word access in address phase
  logic wr_pend_ff; // write data phase pending
  logic [7:0] wr_addr_ff; // latched write offset
  logic [31:0] rd_word; // read mux value

  assign acc = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
  assign hreadyout = 1'b1; // never stalls, so no wait logic
  assign hresp = 1'b0; // always okay, unmapped reads zero

  // address phase capture
  // the offset is kept because haddr moves on to the next transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc && hwrite) begin
        wr_addr_ff <= haddr[7:0];
      end
    end
  end

  // read mux, decoded in the address phase
  // unmapped offsets and unused bits read as zero
  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[7:0] == ADDR_CTRL) begin
      rd_word[1:0] = ctrl_ff;
    end else if (haddr[7:0] == ADDR_MASK) begin
      rd_word[NUM_IN-1:0] = mask_ff;
    end else if (haddr[7:0] == ADDR_LEVEL) begin
      rd_word[NUM_IN-1:0] = lvl;
    end else if (haddr[7:0] == ADDR_EVENT) begin
      rd_word[NUM_EV-1:0] = event_ff;
    end else if (haddr[7:0] == ADDR_PROC) begin
      rd_word[4:0] = proc_num;
    end
  end

  // read data registered so it stands through the data phase
  // a write or idle cycle leaves the last read value standing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // data phase writes; unmapped offsets are dropped silently
  // write data arrive one cycle after their address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= MASK_RST;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == ADDR_CTRL) begin
        ctrl_ff <= hwdata[1:0];
      end else if (wr_addr_ff == ADDR_MASK) begin
        mask_ff <= hwdata[NUM_IN-1:0];
      end
    end
  end

  // event clear strobe comes from the write data phase
  // clears only in a write data phase, so no other hwdata can clear
  assign ev_clr = (wr_pend_ff && wr_addr_ff == ADDR_EVENT) ? hwdata[NUM_EV-1:0] : '0;

endmodule // dicd_top

// ===== dicd_pkg.sv
package dicd_pkg;
  // register byte offsets (haddr[7:0])
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_EVENT = 8'h0C;
  localparam logic [7:0] ADDR_PROC = 8'h10;
  // control register fields
  localparam int CTRL_SEL16_BIT = 0;
  localparam int CTRL_SINGLE_SRC_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // discrete input positions in the internal vector
  localparam int IN_START = 0;
  localparam int IN_STOP = 1;
  localparam int IN_DEP_END = 2;
  localparam int IN_RS_TRIG = 3;
  localparam int IN_RS_INHIB = 4;
  localparam int IN_XF_INHIB = 5;
  localparam int IN_THK_ZERO = 6;
  localparam int IN_SOAK2_HOLD = 7;
  localparam int IN_CRUC1_OK = 8;
  localparam int IN_CRUC2_OK = 9;
  localparam int IN_RESET = 10;
  localparam int IN_SEL0 = 11;
  localparam int NUM_IN = 15;
  localparam logic [14:0] MASK_RST = 15'h7FFF;
  // sticky event bits
  localparam int EV_START = 0;
  localparam int EV_STOP = 1;
  localparam int EV_DEP_END = 2;
  localparam int EV_RS_TRIG = 3;
  localparam int EV_THK_ZERO = 4;
  localparam int EV_RESET = 5;
  localparam int EV_REFUSED = 6;
  localparam int NUM_EV = 7;
  // debounce timing
  localparam int CLK_MHZ = 50;
  localparam int DBNC_TIME_US = 1000;
  localparam int DBNC_CYCLES = DBNC_TIME_US * CLK_MHZ;
  localparam int DBNC_CNT_W = 16;
  // ahb encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// ===== dicd_debounce.sv
`timescale 1ns/1ns
// one contact input: two-flop sync, then a level that only moves after
// the synced sample has stayed different for a full debounce window
module dicd_debounce #(
  parameter int CNT_W = 16,
  parameter int CYCLES = 50000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_n,
  output logic level_ff
);
  logic sync1_ff; // first stage, read only by sync2_ff
  logic sync2_ff; // second stage, safe to use
  logic [CNT_W-1:0] cnt_ff; // cycles the new value has held
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  // synchronise; pin idles high, so reset to high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= pin_n;
      sync2_ff <= sync1_ff;
    end
  end

  // stable-window filter; bounce restarts the window so one closure
  // makes one transition of level_ff
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else if ((~sync2_ff) == level_ff) begin
      cnt_ff <= '0; // agrees, nothing pending
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
      level_ff <= ~sync2_ff; // grounded pin reads as active
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule // dicd_debounce

// ===== dicd_top_chk.sv
`timescale 1ns/1ns
// watches the decoder at its ports only; bound onto every instance of the top
module dicd_top_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic seq_running,
  input wire logic seq_stopped,
  input wire logic seq_ready_or_last_idle,
  input wire logic seq_in_deposit,
  input wire logic film_rate_sample_en,
  input wire logic crystal_fault_det,
  input wire logic crystal_fault_inhibit_n,
  input wire logic soak2_hold_n,
  input wire logic cmd_start,
  input wire logic cmd_deposit_end,
  input wire logic cmd_rate_sample,
  input wire logic cmd_reset,
  input wire logic crystal_fail_relay,
  input wire logic crystal_fail_stop,
  input wire logic soak2_hold,
  input wire logic proc_load,
  input wire logic [4:0] proc_num
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // twelve grounded cycles cover sync, a debounce window of at most 8 cycles and output flop
  sequence xf_low;
    !crystal_fault_inhibit_n [*8] ##1 !crystal_fault_inhibit_n [*4];
  endsequence
  sequence soak_low;
    !soak2_hold_n [*8] ##1 !soak2_hold_n [*4];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered an error");
  a_start_gate: assert property (cmd_start |-> !$past(seq_running))
    else $error("start issued while a layer was running");
  a_reset_gate: assert property (cmd_reset |-> $past(seq_stopped))
    else $error("reset issued outside the stopped condition");
  a_sample_gate: assert property (cmd_rate_sample |-> $past(film_rate_sample_en))
    else $error("rate sample issued for a film without it");
  a_dep_gate: assert property (cmd_deposit_end |-> $past(seq_in_deposit))
    else $error("deposit end issued outside deposit");
  a_load_start: assert property (proc_load |-> cmd_start && $past(seq_ready_or_last_idle))
    else $error("process loaded without a start in ready");
  a_proc_range: assert property (proc_num inside {[5'h01:5'h10]})
    else $error("process number out of range");
  a_start_once: assert property (cmd_start |=> !cmd_start)
    else $error("start pulse longer than one cycle");
  a_fault_cause: assert property (crystal_fail_stop |-> $past(crystal_fault_det) && crystal_fail_relay)
    else $error("crystal stop without a fault or without the relay");
  a_fault_inhib: assert property (xf_low |-> !crystal_fail_stop && !crystal_fail_relay)
    else $error("crystal stop while inhibited");
  a_soak_hold: assert property (soak_low |-> soak2_hold)
    else $error("soak hold not shown while grounded");
endmodule // dicd_top_chk
bind dicd_top dicd_top_chk chk (.hclk, .hresetn, .hreadyout, .hresp, .seq_running, .seq_stopped,
  .seq_ready_or_last_idle, .seq_in_deposit, .film_rate_sample_en, .crystal_fault_det,
  .crystal_fault_inhibit_n, .soak2_hold_n, .cmd_start, .cmd_deposit_end, .cmd_rate_sample,
  .cmd_reset, .crystal_fail_relay, .crystal_fail_stop, .soak2_hold, .proc_load, .proc_num);

// ===== dicd_equip.sv
`timescale 1ns/1ns
// process equipment: contacts that chatter, and a crucible indexer
module dicd_equip
  import dicd_pkg::*;
(
  input wire logic hclk,
  input wire logic [14:0] want,
  input wire logic seq_wait_cruc1,
  input wire logic seq_wait_cruc2,
  output logic [14:0] pin_n
);
  logic [14:0] prev_ff = 15'h0; // closures of the last cycle
  logic [14:0] bnc_ff = 15'h0; // contacts that moved last
  logic [1:0] age_ff = 2'h3; // cycles since the last move
  logic [2:0] ix_ff = 3'h0; // indexer travel time
  logic [14:0] pos; // indexer closures
  // chatter lasts three cycles, well inside the debounce window
  always @(posedge hclk) begin
    prev_ff <= want;
    bnc_ff <= (want != prev_ff) ? (want ^ prev_ff) : bnc_ff;
    age_ff <= (want != prev_ff) ? 2'h0 : ((age_ff == 2'h3) ? age_ff : age_ff + 2'h1);
  end
  // the indexer needs a while before the crucible is in place
  always @(posedge hclk) begin
    ix_ff <= (seq_wait_cruc1 || seq_wait_cruc2) ? ((ix_ff == 3'h7) ? ix_ff : ix_ff + 3'h1) : 3'h0;
  end
  always_comb begin
    pos = 15'h0;
    pos[IN_CRUC1_OK] = seq_wait_cruc1 && ix_ff == 3'h7;
    pos[IN_CRUC2_OK] = seq_wait_cruc2 && ix_ff == 3'h7;
  end
  assign pin_n = ~(want | pos) ^ (bnc_ff & {15{age_ff != 2'h3 && !age_ff[0]}});
endmodule // dicd_equip

// ===== discrete_input_command_decoder_test.sv
`timescale 1ns/1ns
module discrete_input_command_decoder_test;
  import dicd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_ph = 1'b0; // master is in a read data phase
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, proc_load;
  logic [31:0] hrdata;
  logic [5:0] cmd; // pulses, ordered like the event bits
  logic [4:0] lvl; // hold, relay, stop, soak2, proceed
  logic [4:0] proc_num, p;
  logic [14:0] want = 15'h0; // closures asked of the equipment
  logic [14:0] pin_n;
  logic [7:0] st = 8'h0; // run, stopped, ready, deposit, film, wait1, wait2, fault
  logic [31:0] rq[$]; // expected read words
  logic [11:0] cq[$]; // expected command, load, process
  logic [11:0] ex;
  logic [3:0] sel;
  int error_cnt = 0;
  int comparisons = 0;
  integer seed = 34161;
  int pins[6] = '{IN_START, IN_STOP, IN_DEP_END, IN_RS_TRIG, IN_THK_ZERO, IN_RESET};
  dicd_top #(.DBNC_LEN(4)) uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(HSIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
    .start_n(pin_n[IN_START]), .stop_n(pin_n[IN_STOP]), .deposit_end_n(pin_n[IN_DEP_END]),
    .rate_sample_trig_n(pin_n[IN_RS_TRIG]), .rate_sample_inhibit_n(pin_n[IN_RS_INHIB]),
    .crystal_fault_inhibit_n(pin_n[IN_XF_INHIB]), .thick_zero_n(pin_n[IN_THK_ZERO]),
    .soak2_hold_n(pin_n[IN_SOAK2_HOLD]), .cruc1_valid_n(pin_n[IN_CRUC1_OK]),
    .cruc2_valid_n(pin_n[IN_CRUC2_OK]), .reset_n_in(pin_n[IN_RESET]),
    .proc_sel_n(pin_n[14:11]), .seq_running(st[0]), .seq_stopped(st[1]),
    .seq_ready_or_last_idle(st[2]), .seq_in_deposit(st[3]), .film_rate_sample_en(st[4]),
    .seq_wait_cruc1(st[5]), .seq_wait_cruc2(st[6]), .crystal_fault_det(st[7]),
    .cmd_start(cmd[0]), .cmd_stop(cmd[1]), .cmd_deposit_end(cmd[2]),
    .cmd_rate_sample(cmd[3]), .cmd_thick_zero(cmd[4]), .cmd_reset(cmd[5]),
    .rate_sample_hold(lvl[0]), .crystal_fail_relay(lvl[1]), .crystal_fail_stop(lvl[2]),
    .soak2_hold(lvl[3]), .cruc_proceed(lvl[4]), .proc_load, .proc_num);
  dicd_equip eq (.hclk, .want, .seq_wait_cruc1(st[5]), .seq_wait_cruc2(st[6]), .pin_n);
  initial begin
    forever #10 hclk = ~hclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one single word transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    rd_ph <= !wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  // close a contact, then reopen; each part outlasts the debounce
  task automatic press(input int i);
    want[i] <= 1'b1;
    repeat (16) @(posedge hclk);
    want[i] <= 1'b0;
    repeat (16) @(posedge hclk);
  endtask
  task automatic test_done;
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // any pulse is matched with the oldest note; a pulse with no note fails
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1) check(hrdata, rq.pop_front());
    if (hresetn && (cmd !== 6'h0 || proc_load !== 1'b0)) begin
      ex = (cq.size() > 0) ? cq.pop_front() : 12'h0;
      check({20'h0, cmd, proc_load, proc_num}, {20'h0, ex});
    end
  end
  initial begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_MASK, 32'h7FFF);
    rd(ADDR_PROC, 32'h1);
    bus(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0);
    $display("test registers done");
    st <= 8'h1A;
    for (int k = 0; k < 6; k++) begin
      cq.push_back({6'(1 << k), 1'b0, 5'h01});
      press(pins[k]);
    end
    // masked start counts as released
    bus(1'b1, ADDR_MASK, 32'h7FFE);
    press(IN_START);
    bus(1'b1, ADDR_MASK, 32'h7FFF);
    $display("test edges done");
    // sequencer unwilling: only stop and zero go through
    st <= 8'h01;
    for (int k = 0; k < 6; k++) begin
      if (k == 1 || k == 4) cq.push_back({6'(1 << k), 1'b0, 5'h01});
      press(pins[k]);
    end
    rd(ADDR_EVENT, 32'h7F);
    bus(1'b1, ADDR_EVENT, 32'h7F);
    rd(ADDR_EVENT, 32'h0);
    $display("test refusals done");
    // two-input and four-input decoding in turn, last one at process 16
    st <= 8'h04;
    for (int i = 0; i < 6; i++) begin
      sel = (i == 5) ? 4'hF : 4'($random(seed));
      bus(1'b1, ADDR_CTRL, {31'h0, i[0]});
      want[14:11] <= sel;
      repeat (16) @(posedge hclk);
      p = i[0] ? {1'b0, sel} + 5'h01 : {3'h0, sel[1:0]} + 5'h01;
      cq.push_back({6'h01, 1'b1, p});
      press(IN_START);
    end
    rd(ADDR_PROC, {27'h0, p});
    $display("test process select done");
    want <= (15'h1 << IN_RS_INHIB) | (15'h1 << IN_SOAK2_HOLD);
    st <= 8'h90;
    repeat (16) @(posedge hclk);
    check(lvl[0], 1'b1);
    check(lvl[3], 1'b1);
    check(lvl[2:1], 2'h3);
    press(IN_RS_TRIG);
    want[IN_XF_INHIB] <= 1'b1;
    repeat (16) @(posedge hclk);
    check(lvl[2:1], 2'h0);
    want <= 15'h0;
    st <= 8'h20;
    repeat (24) @(posedge hclk);
    check(lvl[4], 1'b1);
    st <= 8'h00;
    repeat (4) @(posedge hclk);
    st <= 8'h40;
    repeat (4) @(posedge hclk);
    check(lvl[4], 1'b0);
    repeat (20) @(posedge hclk);
    check(lvl[4], 1'b1);
    // single source: source 2 now follows the source 1 input only
    bus(1'b1, ADDR_CTRL, 32'h2);
    repeat (4) @(posedge hclk);
    check(lvl[4], 1'b0);
    want[IN_CRUC1_OK] <= 1'b1;
    repeat (16) @(posedge hclk);
    check(lvl[4], 1'b1);
    check(cq.size(), 0);
    $display("test levels done");
    test_done();
  end
endmodule // discrete_input_command_decoder_test
